// ### hw/sirf_pkg.sv
// Constants and types shared by the supply integrity and reset flag block.
package sirf_pkg;

    localparam int          CLK_PERIOD_NS  = 40;
    localparam int          T_RSTL_OUT_NS  = 500;
    localparam int          WDG_MIN_CYC    =
        (T_RSTL_OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [12:0] WDG_MIN_LOAD   = 13'(WDG_MIN_CYC - 1);
    localparam int          DLY_SHORT_CYC  = 256;
    localparam int          DLY_LONG_CYC   = 4096;
    localparam logic [12:0] DLY_SHORT_LOAD = 13'(DLY_SHORT_CYC - 1);
    localparam logic [12:0] DLY_LONG_LOAD  = 13'(DLY_LONG_CYC - 1);

    localparam int          WB_ADR_W       = 4;
    localparam logic [3:0]  ICSR_ADDR      = 4'h0;

    localparam int          BIT_WATCHDOG_RESET_FLAG      = 0;
    localparam int          BIT_LOWVOLT_RESET_FLAG      = 4;
    localparam int          BIT_FLAG       = 5;
    localparam int          BIT_IRQ_EN     = 6;
    localparam logic [7:0]  ICSR_RESET     = 8'h00;

    typedef enum logic [2:0] {
        SIRF_IDLE   = 3'b001,
        SIRF_ACTIVE = 3'b010,
        SIRF_DELAY  = 3'b100
    } sirf_state_t;

    typedef enum logic [1:0] {
        SIRF_SRC_EXT = 2'h0,
        SIRF_SRC_WDG = 2'h1,
        SIRF_SRC_LVD = 2'h2
    } sirf_src_t;

    typedef struct packed {
        logic                cyc;
        logic                stb;
        logic                we;
        logic [WB_ADR_W-1:0] adr;
        logic [3:0]          sel;
        logic [31:0]         dat;
    } sirf_wb_req_t;

endpackage : sirf_pkg

// ### hw/sirf_top.sv
// Supply integrity monitor, reset sequencer and reset source flags.
`timescale 1ns/1ps

module sirf_top (
    input  wire logic              I_CLK,
    input  wire logic              I_RST_N,
    input  wire sirf_pkg::sirf_wb_req_t I_WB,
    output logic [31:0]            O_WB_DAT,
    output logic                   O_WB_ACK,
    input  wire logic              I_LVD_OPT_EN,
    input  wire logic              I_LONG_DLY_OPT,
    input  wire logic              I_LVD_LOW,
    input  wire logic              I_AVD_LOW,
    input  wire logic              I_WDG_UFLOW,
    input  wire logic              I_RST_PIN_IN,
    output logic                   O_RST_PIN_OUT,
    output logic                   O_RST_PIN_OE,
    output logic                   O_CPU_RST_N,
    input  wire logic              I_HALT,
    input  wire logic              I_WAIT,
    input  wire logic              I_CC_MASK,
    input  wire logic              I_IRQ_ACK,
    output logic                   O_IRQ,
    output logic                   O_WAKE
);
    import sirf_pkg::*;

    function automatic logic [7:0] icsr_image(
        input logic en,
        input logic flag,
        input logic lowvolt_reset_flag,
        input logic watchdog_reset_flag
    );
        logic [7:0] v;
        v = 8'h00;
        v[BIT_IRQ_EN] = en;
        v[BIT_FLAG]   = flag;
        v[BIT_LOWVOLT_RESET_FLAG]  = lowvolt_reset_flag;
        v[BIT_WATCHDOG_RESET_FLAG]  = watchdog_reset_flag;
        return v;
    endfunction : icsr_image

    // Reset sequencer state.
    sirf_state_t state_ff;
    sirf_state_t nxt_state;
    sirf_src_t   src_ff;
    sirf_src_t   nxt_src;
    logic [12:0] cnt_ff;
    logic [12:0] nxt_cnt;
    logic        oe_ff;
    logic        nxt_oe;
    logic        cpu_rst_n_ff;
    logic        nxt_cpu_rst_n;
    logic        lvd_low;
    logic        set_lvd;
    logic        set_wdg;

    assign lvd_low = I_LVD_LOW & I_LVD_OPT_EN;

    always_comb begin
        nxt_state = state_ff;
        nxt_src   = src_ff;
        nxt_cnt   = cnt_ff;
        set_lvd   = 1'b0;
        set_wdg   = 1'b0;
        case (state_ff)
            SIRF_IDLE: begin
                if (lvd_low) begin
                    nxt_state = SIRF_ACTIVE;
                    nxt_src   = SIRF_SRC_LVD;
                    set_lvd   = 1'b1;
                end else if (I_WDG_UFLOW) begin
                    nxt_state = SIRF_ACTIVE;
                    nxt_src   = SIRF_SRC_WDG;
                    nxt_cnt   = WDG_MIN_LOAD;
                    set_wdg   = 1'b1;
                end else if (!I_RST_PIN_IN && !oe_ff) begin
                    nxt_state = SIRF_ACTIVE;
                    nxt_src   = SIRF_SRC_EXT;
                end
            end
            SIRF_ACTIVE: begin
                if (lvd_low) begin
                    nxt_src = SIRF_SRC_LVD;
                    set_lvd = (src_ff != SIRF_SRC_LVD);
                end else if (src_ff == SIRF_SRC_WDG && cnt_ff != 13'h0) begin
                    nxt_cnt = cnt_ff - 13'h1;
                end else if (src_ff == SIRF_SRC_EXT && !I_RST_PIN_IN) begin
                    nxt_state = SIRF_ACTIVE;
                end else begin
                    nxt_state = SIRF_DELAY;
                    nxt_cnt   = I_LONG_DLY_OPT ? DLY_LONG_LOAD
                                               : DLY_SHORT_LOAD;
                end
            end
            SIRF_DELAY: begin
                if (lvd_low) begin
                    nxt_state = SIRF_ACTIVE;
                    nxt_src   = SIRF_SRC_LVD;
                    set_lvd   = 1'b1;
                end else if (I_WDG_UFLOW) begin
                    nxt_state = SIRF_ACTIVE;
                    nxt_src   = SIRF_SRC_WDG;
                    nxt_cnt   = WDG_MIN_LOAD;
                    set_wdg   = 1'b1;
                end else if (cnt_ff == 13'h0) begin
                    nxt_state = SIRF_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - 13'h1;
                end
            end
            default: begin
                nxt_state = SIRF_IDLE;
            end
        endcase
        // An external source already holds the pin low, so it is left
        // undriven then; otherwise its release could never be seen.
        nxt_oe = (nxt_state == SIRF_DELAY) ||
                 (nxt_state == SIRF_ACTIVE &&
                  nxt_src != SIRF_SRC_EXT);
        nxt_cpu_rst_n = (nxt_state == SIRF_IDLE);
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_ff     <= SIRF_IDLE;
            src_ff       <= SIRF_SRC_EXT;
            cnt_ff       <= 13'h0;
            oe_ff        <= 1'b0;
            cpu_rst_n_ff <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            src_ff       <= nxt_src;
            cnt_ff       <= nxt_cnt;
            oe_ff        <= nxt_oe;
            cpu_rst_n_ff <= nxt_cpu_rst_n;
        end
    end

    // Wishbone slave, one wait state; a write lands on the ack edge.
    logic        ack_ff;
    logic        nxt_ack;
    logic [31:0] dat_ff;
    logic [31:0] nxt_dat;
    logic        wb_req;
    logic        hit;
    logic        wr_now;

    assign wb_req = I_WB.cyc & I_WB.stb;
    assign hit    = (I_WB.adr == ICSR_ADDR);
    assign wr_now = wb_req & ack_ff & I_WB.we & hit & I_WB.sel[0];

    // Integrity register state.
    logic en_ff;
    logic nxt_en;
    logic flag_ff;
    logic nxt_flag;
    logic pend_ff;
    logic nxt_pend;
    logic lowvolt_reset_flag_ff;
    logic nxt_lowvolt_reset_flag;
    logic watchdog_reset_flag_ff;
    logic nxt_watchdog_reset_flag;
    logic in_rst;
    logic toggle;
    logic en_rise;

    assign in_rst = (state_ff != SIRF_IDLE);

    always_comb begin
        nxt_ack = wb_req & ~ack_ff;
        nxt_dat = 32'h0;
        if (wb_req && !ack_ff && hit) begin
            nxt_dat = {24'h0, icsr_image(en_ff, flag_ff,
                                         lowvolt_reset_flag_ff, watchdog_reset_flag_ff)};
        end
    end

    always_comb begin
        nxt_flag = flag_ff;
        nxt_en   = en_ff;
        if (!I_HALT) begin
            nxt_flag = I_AVD_LOW & I_LVD_OPT_EN;
            if (wr_now) begin
                nxt_en = I_WB.dat[BIT_IRQ_EN];
            end
        end
        if (in_rst) begin
            nxt_en = 1'b0;
        end
        // Changes are latched even while disabled, so that enabling after
        // the supply has recovered still reports that change once.
        toggle  = (nxt_flag != flag_ff);
        // Enabling while the warning is up asks for service at once.
        en_rise = nxt_en & ~en_ff & flag_ff;
        nxt_pend = pend_ff;
        if (I_IRQ_ACK) begin
            nxt_pend = 1'b0;
        end
        if (!I_HALT && (toggle || en_rise)) begin
            nxt_pend = 1'b1;
        end
        if (in_rst) begin
            nxt_pend = 1'b0;
        end
        // Hardware sets win over a zero written in the same cycle; a one
        // written to either flag has no effect.
        nxt_lowvolt_reset_flag = lowvolt_reset_flag_ff;
        nxt_watchdog_reset_flag = watchdog_reset_flag_ff;
        if (wr_now && !I_HALT) begin
            if (!I_WB.dat[BIT_LOWVOLT_RESET_FLAG]) begin
                nxt_lowvolt_reset_flag = 1'b0;
            end
            if (!I_WB.dat[BIT_WATCHDOG_RESET_FLAG]) begin
                nxt_watchdog_reset_flag = 1'b0;
            end
        end
        if (set_wdg) begin
            nxt_watchdog_reset_flag = 1'b1;
        end
        if (set_lvd) begin
            nxt_lowvolt_reset_flag = 1'b1;
            nxt_watchdog_reset_flag = 1'b0;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ack_ff   <= 1'b0;
            dat_ff   <= 32'h0;
            en_ff    <= ICSR_RESET[BIT_IRQ_EN];
            flag_ff  <= ICSR_RESET[BIT_FLAG];
            pend_ff  <= 1'b0;
            lowvolt_reset_flag_ff <= ICSR_RESET[BIT_LOWVOLT_RESET_FLAG];
            watchdog_reset_flag_ff <= ICSR_RESET[BIT_WATCHDOG_RESET_FLAG];
        end else begin
            ack_ff   <= nxt_ack;
            dat_ff   <= nxt_dat;
            en_ff    <= nxt_en;
            flag_ff  <= nxt_flag;
            pend_ff  <= nxt_pend;
            lowvolt_reset_flag_ff <= nxt_lowvolt_reset_flag;
            watchdog_reset_flag_ff <= nxt_watchdog_reset_flag;
        end
    end

    // Interrupt and wake outputs.
    logic irq_ff;
    logic nxt_irq;
    logic wake_ff;
    logic nxt_wake;

    always_comb begin
        nxt_irq  = nxt_pend & nxt_en & ~I_CC_MASK;
        nxt_wake = nxt_irq & I_WAIT & ~I_HALT;
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            irq_ff  <= 1'b0;
            wake_ff <= 1'b0;
        end else begin
            irq_ff  <= nxt_irq;
            wake_ff <= nxt_wake;
        end
    end

    assign O_WB_ACK      = ack_ff;
    assign O_WB_DAT      = dat_ff;
    assign O_RST_PIN_OUT = 1'b0 & oe_ff;
    assign O_RST_PIN_OE  = oe_ff;
    assign O_CPU_RST_N   = cpu_rst_n_ff;
    assign O_IRQ         = irq_ff;
    assign O_WAKE        = wake_ff;

    // Helper: length of the last delay phase, for checking only.
    logic [12:0] dly_run;
    logic        dly_long;

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            dly_run  <= 13'h0;
            dly_long <= 1'b0;
        end else if (state_ff == SIRF_DELAY) begin
            dly_run <= dly_run + 13'h1;
        end else begin
            dly_run  <= 13'h0;
            dly_long <= I_LONG_DLY_OPT;
        end
    end

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);

    sequence s_wdg_start;
        state_ff == SIRF_IDLE && !lvd_low && I_WDG_UFLOW;
    endsequence

    sequence s_pin_held8;
        O_RST_PIN_OE [*8];
    endsequence

    a_lvd_pin_low: assert property (
        lvd_low |=> O_RST_PIN_OE && !O_CPU_RST_N)
        else $error("low supply did not pull the reset pin");

    a_lvd_static_hold: assert property (
        lvd_low [*3] |-> O_RST_PIN_OE && state_ff == SIRF_ACTIVE)
        else $error("low-voltage reset released while supply low");

    a_wdg_min_pulse: assert property (
        s_wdg_start |=> s_pin_held8 ##1 O_RST_PIN_OE [*5])
        else $error("watchdog reset pulse too short");

    a_delay_length: assert property (
        state_ff == SIRF_DELAY && nxt_state == SIRF_IDLE
        |-> dly_run == (dly_long ? DLY_LONG_LOAD : DLY_SHORT_LOAD))
        else $error("reset delay phase has the wrong length");

    a_delay_pin_low: assert property (
        state_ff == SIRF_DELAY |-> O_RST_PIN_OE && !O_CPU_RST_N)
        else $error("reset pin released during delay phase");

    a_flag_tracks: assert property (
        !I_HALT |=> flag_ff == $past(I_AVD_LOW && I_LVD_OPT_EN))
        else $error("warning flag does not follow comparator");

    a_toggle_pend: assert property (
        en_ff && !I_HALT && !in_rst && !$stable(I_AVD_LOW)
        && I_LVD_OPT_EN && $stable(I_LVD_OPT_EN)
        ##1 (flag_ff != $past(flag_ff)) |-> pend_ff)
        else $error("flag change raised no interrupt");

    a_ack_clears: assert property (
        I_IRQ_ACK && !toggle && !en_rise |=> !pend_ff)
        else $error("service entry did not clear pending");

    a_irq_gated: assert property (
        O_IRQ |-> $past(nxt_pend && nxt_en && !I_CC_MASK))
        else $error("interrupt raised while masked or disabled");

    a_halt_frozen: assert property (
        I_HALT && !in_rst && !set_lvd && !set_wdg
        |=> $stable(flag_ff) && $stable(en_ff))
        else $error("integrity register changed in halt");

    a_lvd_flags: assert property (
        set_lvd |=> lowvolt_reset_flag_ff && !watchdog_reset_flag_ff)
        else $error("low-voltage reset flags wrong");

    a_wb_handshake: assert property (
        wb_req && !ack_ff |=> ack_ff ##1 !ack_ff)
        else $error("bus ack not a single cycle after request");

endmodule : sirf_top

// ### verif/sirf_partner.sv
// Model of the supply comparators, watchdog and open-drain reset pin.
`timescale 1ns/1ps
module sirf_partner (
    input  wire logic i_clk,
    input  wire logic i_lvd,
    input  wire logic i_avd,
    input  wire logic i_wdg,
    input  wire logic i_ext,
    input  wire logic i_oe,
    output logic      o_lvd_low = 1'b0,
    output logic      o_avd_low = 1'b0,
    output logic      o_wdg_uflow = 1'b0,
    output logic      o_pin
);
    // The pin has a pull-up, so it reads high once every driver lets go.
    assign o_pin = ~(i_oe | i_ext);
    // Comparators settle a cycle after the supply moves, as real ones lag.
    always @(posedge i_clk) begin
        o_lvd_low   <= i_lvd;
        o_avd_low   <= i_avd;
        o_wdg_uflow <= i_wdg;
    end
endmodule : sirf_partner

// ### verif/sirf_top_bench.sv
// Self-checking bench for the supply integrity and reset flag block.
`timescale 1ns/1ps
module sirf_top_bench;
    import sirf_pkg::*;
    logic         clk, rst_n, lvd_opt, long_opt, low_voltage_detector, auxiliary_voltage_detector, wdg, ext;
    logic         lvd_low, avd_low, wdg_uf, pin, oe, pin_out, cpu_rst_n;
    logic         halt, wt, mask, iack, irq, wake, wb_ack;
    sirf_wb_req_t wb_req;
    logic [31:0]  wb_dat;
    int           num_errors = 0;
    int           n_checks = 0;

    sirf_partner part_u (.i_clk(clk), .i_lvd(low_voltage_detector), .i_avd(auxiliary_voltage_detector), .i_wdg(wdg),
        .i_ext(ext), .i_oe(oe), .o_lvd_low(lvd_low), .o_avd_low(avd_low),
        .o_wdg_uflow(wdg_uf), .o_pin(pin));
    sirf_top dut_u (.I_CLK(clk), .I_RST_N(rst_n), .I_WB(wb_req),
        .O_WB_DAT(wb_dat), .O_WB_ACK(wb_ack), .I_LVD_OPT_EN(lvd_opt),
        .I_LONG_DLY_OPT(long_opt), .I_LVD_LOW(lvd_low), .I_AVD_LOW(avd_low),
        .I_WDG_UFLOW(wdg_uf), .I_RST_PIN_IN(pin), .O_RST_PIN_OUT(pin_out),
        .O_RST_PIN_OE(oe), .O_CPU_RST_N(cpu_rst_n), .I_HALT(halt),
        .I_WAIT(wt), .I_CC_MASK(mask), .I_IRQ_ACK(iack), .O_IRQ(irq),
        .O_WAKE(wake));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task complete_run;
        $display("Checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
        end
    endtask : chk

    // The master waits for ack however long it takes; only the watchdog
    // below ends a wait that hangs.
    task wb(input logic w, input logic [3:0] a, input logic [7:0] d,
            output logic [7:0] q);
        wb_req <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
        do begin
            @(posedge clk);
        end while (wb_ack !== 1'b1);
        q = wb_dat[7:0];
        chk("dat upper", 8'h0, 8'(wb_dat[31:8] != 24'h0));
        wb_req <= '0;
        @(posedge clk);
        chk("ack drop", 8'h0, 8'(wb_ack));
    endtask : wb

    task rchk(input string nm, input logic [3:0] a, input logic [7:0] e);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, q);
        chk(nm, e, q);
    endtask : rchk

    task wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    // Counts reset cycles from the call until the CPU is let go.
    task rst_seq(input string nm, input int clo, input int olo);
        int n, m;
        n = 0;
        m = 0;
        repeat (6000) begin
            @(negedge clk);
            if (oe === 1'b1) m++;
            if (cpu_rst_n === 1'b0) n++;
            else if (n > 0) break;
        end
        @(posedge clk);
        chk({nm, " cpu"}, 8'h1,
            8'(n >= clo && n <= clo + 6));
        chk({nm, " pin"}, 8'h1,
            8'(m >= olo && m <= olo + 6));
    endtask : rst_seq

    task t_regs;
        rchk("reset value", ICSR_ADDR, ICSR_RESET);
        // Software keeps the reserved bits clear; the ones written elsewhere
        // probe the read-only flag and the write-zero-to-clear flags.
        wr(ICSR_ADDR, 8'h71);
        rchk("reserved", ICSR_ADDR, 8'h40);
        wr(4'h4, 8'h00);
        rchk("unmapped", 4'h4, 8'h00);
        rchk("unmapped wr", ICSR_ADDR, 8'h40);
        $display("Test registers done");
    endtask : t_regs

    task t_src(input logic w, input string nm, input int clo, input int olo,
               input logic [7:0] e);
        wdg <= w;
        ext <= ~w;
        repeat (w ? 1 : 5) @(posedge clk);
        wdg <= 1'b0;
        ext <= 1'b0;
        rst_seq(nm, clo, olo);
        rchk(nm, ICSR_ADDR, e);
        $display("Test %s done", nm);
    endtask : t_src

    task t_lvd;
        wr(ICSR_ADDR, 8'h40);
        long_opt <= 1'b1;
        low_voltage_detector <= 1'b1;
        auxiliary_voltage_detector <= 1'b1;
        repeat (40) @(posedge clk);
        chk("lvd pin held", 8'h1, 8'(oe));
        chk("pin level", 8'h0, 8'(pin_out));
        chk("lvd cpu held", 8'h0, 8'(cpu_rst_n));
        low_voltage_detector <= 1'b0;
        repeat (10) @(posedge clk);
        auxiliary_voltage_detector <= 1'b0;
        // The option is read as the delay starts, so it stays up until then.
        rst_seq("lvd reset", DLY_LONG_CYC - 10,
                DLY_LONG_CYC - 10);
        long_opt <= 1'b0;
        chk("rise in delay", 8'h0, 8'(irq));
        rchk("lvd flags", ICSR_ADDR, 8'h10);
        $display("Test lvd reset done");
    endtask : t_lvd

    task t_clear;
        wr(ICSR_ADDR, 8'h11);
        rchk("flags kept", ICSR_ADDR, 8'h11);
        wr(ICSR_ADDR, 8'h00);
        rchk("flags cleared", ICSR_ADDR, 8'h00);
        $display("Test flag clear done");
    endtask : t_clear

    task ichk(input string nm, input logic e);
        repeat (4) @(posedge clk);
        chk(nm, 8'(e), 8'(irq));
    endtask : ichk

    task ack_irq;
        iack <= 1'b1;
        @(posedge clk);
        iack <= 1'b0;
        ichk("irq cleared", 1'b0);
    endtask : ack_irq

    task t_irq;
        logic [7:0] q;
        auxiliary_voltage_detector <= 1'b1;
        ichk("irq disabled", 1'b0);
        rchk("flag live", ICSR_ADDR, 8'h20);
        auxiliary_voltage_detector <= 1'b0;
        ichk("rise unseen", 1'b0);
        wr(ICSR_ADDR, 8'h40);
        ichk("irq late enable", 1'b1);
        ack_irq();
        ichk("single irq", 1'b0);
        wr(ICSR_ADDR, 8'h00);
        auxiliary_voltage_detector <= 1'b1;
        ichk("irq off again", 1'b0);
        wr(ICSR_ADDR, 8'h40);
        ichk("irq on enable", 1'b1);
        ack_irq();
        mask <= 1'b1;
        auxiliary_voltage_detector <= 1'b0;
        ichk("irq masked", 1'b0);
        mask <= 1'b0;
        ichk("irq unmasked", 1'b1);
        ack_irq();
        wt <= 1'b1;
        auxiliary_voltage_detector <= 1'b1;
        repeat (4) @(posedge clk);
        chk("wake", 8'h1, 8'(wake));
        ack_irq();
        wt <= 1'b0;
        halt <= 1'b1;
        auxiliary_voltage_detector <= 1'b0;
        ichk("halt irq", 1'b0);
        rchk("halt frozen", ICSR_ADDR, 8'h60);
        halt <= 1'b0;
        ichk("after halt", 1'b1);
        ack_irq();
        lvd_opt <= 1'b0;
        auxiliary_voltage_detector <= 1'b1;
        ichk("opt off irq", 1'b0);
        // Neither reset flag is compared here; the low-voltage one cannot be set with the detector option off.
        wb(1'b0, ICSR_ADDR, 8'h00, q);
        chk("opt off flag", 8'h40, q & 8'hee);
        $display("Test irq done");
    endtask : t_irq

    initial begin
        wb_req = '0;
        {lvd_opt, long_opt, low_voltage_detector, auxiliary_voltage_detector, wdg, ext} = 6'h20;
        {halt, wt, mask, iack, rst_n} = 5'h00;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_src(1'b1, "wdg reset", WDG_MIN_CYC + DLY_SHORT_CYC,
              WDG_MIN_CYC + DLY_SHORT_CYC, 8'h01);
        t_lvd();
        t_src(1'b0, "ext after lvd", DLY_SHORT_CYC, DLY_SHORT_CYC,
              8'h10);
        t_src(1'b1, "wdg after lvd", WDG_MIN_CYC + DLY_SHORT_CYC,
              WDG_MIN_CYC + DLY_SHORT_CYC, 8'h11);
        t_clear();
        t_src(1'b0, "ext reset", DLY_SHORT_CYC, DLY_SHORT_CYC,
              8'h00);
        t_irq();
        complete_run();
    end

    // The run needs about five and a half thousand cycles; this is a wide margin.
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        complete_run();
    end
endmodule : sirf_top_bench
